// File: core/tff_params.svh
/*
  constants for the triggered field filter: defaults, limits and timing.
  assumes a 25 MHz system clock and raw readings scaled by the surrounding
  design so that one count is one gauss.
*/
`ifndef TFF_PARAMS_SVH
`define TFF_PARAMS_SVH

// clock rate in hertz
`define TFF_CLK_HZ          25000000
// continuous sample period in milliseconds (ten readings per second)
`define TFF_SAMPLE_PERIOD_MS 100
// latest capture after a trigger, milliseconds
`define TFF_CAPTURE_MAX_MS  10
// latest result after a trigger, milliseconds
`define TFF_READY_MAX_MS    175
// cycle counts derived from the times (longest times round down)
`define TFF_SAMPLE_CYC  ((`TFF_CLK_HZ / 1000) * `TFF_SAMPLE_PERIOD_MS)
`define TFF_CAPTURE_CYC ((`TFF_CLK_HZ / 1000) * `TFF_CAPTURE_MAX_MS)
`define TFF_READY_CYC   ((`TFF_CLK_HZ / 1000) * `TFF_READY_MAX_MS)
// reload value of the filter factor
`define TFF_DIVISOR_DEF     16'h0029
// reload value of the band half-width (counts, one gauss each)
`define TFF_BAND_DEF        16'h0001
// largest band half-width accepted
`define TFF_BAND_MAX        17'h0_FFFE
// cycles reserved for the divider on one update (it uses DW + 1)
`define TFF_DIV_CYC         40

`endif

// File: core/tff_pkg.sv
/*
  types for the triggered field filter.
  assumes tff_params.svh is available on the include path.
*/
package tff_pkg;

  // host commands decoded outside and presented as one-cycle strobes
  typedef struct packed {
    logic        filter_on;        // smoothing on
    logic        filter_off;       // command smoothing off; the filter switch still turns smoothing on
    logic        divisor_set;      // new filter factor
    logic        band_set;         // new band half-width
    logic        arm_trigger;      // enter triggered operation
    logic        continuous;       // back to continuous operation
    logic        trigger;          // broadcast trigger
    logic        auto_send_on;     // enable unprompted sending
    logic        auto_send_off;    // disable unprompted sending
    logic        field_read;       // field-read request
    logic        zero;             // zero request (key or command)
    logic        reload;           // reload defaults
  } tff_cmd_t;

  // measurement sequencer states
  typedef enum logic [2:0] {
    TFF_IDLE,
    TFF_CAPTURE,
    TFF_COMPUTE,
    TFF_WAIT_READY
  } tff_state_t;

endpackage

// File: core/tff_divider.sv
/*
  signed restoring divider, one quotient bit per cycle.
  assumes the caller holds operands stable from start until done.
*/
`timescale 1ns/1ps
`default_nettype none

module tff_divider
  import tff_pkg::*;
#(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  // request
  input  wire logic         start_i,
  input  wire logic [W-1:0] dividend_i,
  input  wire logic [15:0]  divisor_i,
  // answer
  output logic              done_o,
  output logic [W-1:0]      quotient_o
);

  initial begin
    if (W < 17) $error("tff_divider: W too small");
  end

  logic [W-1:0]   rem_reg;     // partial remainder
  logic [W-1:0]   quo_reg;     // magnitude of quotient being built
  logic [W-1:0]   mag_reg;     // shifting dividend magnitude
  logic           neg_reg;     // sign of the result
  logic [5:0]     cnt_reg;     // bits left
  logic           busy_reg;    // division in progress
  logic [W-1:0]   trial;       // remainder after shift

  // trial remainder with next dividend bit shifted in
  assign trial = {rem_reg[W-2:0], mag_reg[W-1]};

  // iteration: magnitude division then sign fix on the last step
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rem_reg  <= '0;
      quo_reg  <= '0;
      mag_reg  <= '0;
      neg_reg  <= 1'b0;
      cnt_reg  <= 6'h00;
      busy_reg <= 1'b0;
      done_o   <= 1'b0;
      quotient_o <= '0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        // take magnitude; the caller never passes a zero divisor
        rem_reg  <= '0;
        quo_reg  <= '0;
        mag_reg  <= dividend_i[W-1] ? -dividend_i : dividend_i;
        neg_reg  <= dividend_i[W-1];
        cnt_reg  <= 6'(W);
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        mag_reg <= {mag_reg[W-2:0], 1'b0};
        if (trial >= W'(divisor_i)) begin
          rem_reg <= trial - W'(divisor_i);
          quo_reg <= {quo_reg[W-2:0], 1'b1};
        end else begin
          rem_reg <= trial;
          quo_reg <= {quo_reg[W-2:0], 1'b0};
        end
        cnt_reg <= cnt_reg - 6'h01;
        if (cnt_reg == 6'h01) begin
          busy_reg   <= 1'b0;
          done_o     <= 1'b1;
          quotient_o <= neg_reg ?
                        -{quo_reg[W-2:0], (trial >= W'(divisor_i))} :
                        {quo_reg[W-2:0], (trial >= W'(divisor_i))};
        end
      end
    end
  end

endmodule

`default_nettype wire

// File: core/tff_core.sv
/*
  triggered field filter: windowed recursive smoothing of raw readings plus
  triggered acquisition control.
  assumes the host command parser delivers one-cycle command strobes with
  their operands, and an external converter returns a raw reading when asked.
*/
`timescale 1ns/1ps
`default_nettype none

`include "tff_params.svh"

module tff_core
  import tff_pkg::*;
#(
  parameter int RAW_W       = 24,
  parameter int SAMPLE_CYC  = `TFF_SAMPLE_CYC,
  parameter int CAPTURE_CYC = `TFF_CAPTURE_CYC,
  parameter int READY_CYC   = `TFF_READY_CYC
) (
  // clock and reset
  input  wire logic              CLK_I,
  input  wire logic              NRST_I,
  // host command strobes and operands
  input  wire tff_cmd_t          CMD_I,
  input  wire logic [16:0]       CMD_VALUE_I,
  input  wire logic              UNIT_SELECTED_I,
  // switches and configuration levels
  input  wire logic              FILTER_SWITCH_I,
  input  wire logic              AUTO_SEND_SWITCH_I,
  input  wire logic              DEFAULTS_RELOAD_SWITCH_I,
  input  wire logic              AC_MODE_I,
  input  wire logic [7:0]        UNIT_ADDRESS_I,
  // raw converter
  output logic                   SAMPLE_REQ_O,
  input  wire logic              SAMPLE_VALID_I,
  input  wire logic signed [RAW_W-1:0] SAMPLE_DATA_I,
  // results
  output logic signed [RAW_W-1:0] FILTERED_O,
  output logic                   RESULT_READY_O,
  output logic                   SEND_O,
  output logic                   READ_REPLY_O,
  output logic signed [RAW_W-1:0] ZERO_OFFSET_O,
  output logic                   ZERO_STORED_O,
  // status
  output logic                   TRIG_MODE_O,
  output logic                   FILTER_ON_O,
  output logic                   BUSY_O,
  output logic                   TOO_BIG_O,
  output logic                   RELOAD_DONE_O,
  output logic [15:0]            DIVISOR_O,
  output logic [15:0]            BAND_O,
  output logic [7:0]             MODE_LETTER_AC_O,
  output logic [7:0]             MODE_LETTER_TRIG_O
);

  localparam int DW = RAW_W + 2;   // divider width with headroom

  initial begin
    if (RAW_W < 17 || RAW_W > 30) $error("tff_core: RAW_W out of range");
    if (READY_CYC <= CAPTURE_CYC + `TFF_DIV_CYC + 4)
      $error("tff_core: READY_CYC too short for capture and compute");
    if (SAMPLE_CYC < 8) $error("tff_core: SAMPLE_CYC too short");
  end

  // absolute value of a signed difference
  function automatic logic [DW-1:0] tff_abs(input logic signed [DW-1:0] v);
    tff_abs = v[DW-1] ? DW'(-v) : DW'(v);
  endfunction

  // sign-extend a raw reading to divider width
  function automatic logic signed [DW-1:0] tff_ext(
    input logic signed [RAW_W-1:0] v);
    tff_ext = DW'(v);
  endfunction

  tff_state_t               state_reg;      // sequencer state
  logic                     trig_mode_reg;  // triggered operation
  logic                     filt_cmd_reg;   // smoothing by command
  logic                     auto_cmd_reg;   // auto-send by command
  logic                     auto_dis_reg;   // auto-send disabled by command
  logic [15:0]              divisor_reg;    // filter factor
  logic [15:0]              band_reg;       // band half-width
  logic                     reload_sw_reg;  // previous reload switch level
  logic [31:0]              tick_reg;       // continuous sample timer
  logic [31:0]              since_reg;      // cycles since trigger
  logic                     from_trig_reg;  // current measurement triggered
  logic signed [RAW_W-1:0]  disp_reg;       // displayed value
  logic signed [RAW_W-1:0]  raw_reg;        // captured raw reading
  logic                     pending_reg;    // result held for read
  logic                     div_start_reg;  // divider start pulse
  logic                     div_done;       // divider finished
  logic [DW-1:0]            div_q;          // divider quotient
  logic signed [DW-1:0]     diff;           // raw minus displayed
  logic                     in_band;        // reading inside band
  logic                     filter_on;      // effective smoothing enable
  logic                     reload;         // defaults reload event
  logic                     trig_accept;    // trigger accepted this cycle
  logic                     auto_send;      // unprompted sending allowed

  // smoothing on by switch or command
  assign filter_on = FILTER_SWITCH_I | filt_cmd_reg;
  // reload on command or rising switch
  assign reload = CMD_I.reload | (DEFAULTS_RELOAD_SWITCH_I & ~reload_sw_reg);
  // broadcast trigger, taken without unit select, only when armed and idle
  assign trig_accept = CMD_I.trigger & trig_mode_reg
                       & (state_reg == TFF_IDLE);
  // auto-send decision
  assign auto_send = ~auto_dis_reg &
                     (auto_cmd_reg |
                      (AUTO_SEND_SWITCH_I && UNIT_ADDRESS_I == 8'h00));
  // difference of raw reading from displayed value, raw input unprocessed
  assign diff = tff_ext(raw_reg) - tff_ext(disp_reg);
  // band test against half-width on each side
  assign in_band = tff_abs(diff) <= DW'(band_reg);

  // configuration: factor, band, smoothing and send modes
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      divisor_reg   <= `TFF_DIVISOR_DEF;
      band_reg      <= `TFF_BAND_DEF;
      filt_cmd_reg  <= 1'b0;
      auto_cmd_reg  <= 1'b0;
      auto_dis_reg  <= 1'b0;
      trig_mode_reg <= 1'b0;
      reload_sw_reg <= 1'b0;
      TOO_BIG_O     <= 1'b0;
      RELOAD_DONE_O <= 1'b0;
    end else begin
      reload_sw_reg <= DEFAULTS_RELOAD_SWITCH_I;
      TOO_BIG_O     <= 1'b0;
      RELOAD_DONE_O <= reload;
      if (reload) begin
        // reinstate defaults
        divisor_reg   <= `TFF_DIVISOR_DEF;
        band_reg      <= `TFF_BAND_DEF;
        filt_cmd_reg  <= 1'b0;
        auto_cmd_reg  <= 1'b0;
        auto_dis_reg  <= 1'b0;
        trig_mode_reg <= 1'b0;
      end else begin
        // a zero factor would divide by zero: refused
        if (CMD_I.divisor_set &&
            CMD_VALUE_I[15:0] != 16'h0000 && !CMD_VALUE_I[16])
          divisor_reg <= CMD_VALUE_I[15:0];
        if (CMD_I.band_set) begin
          if (CMD_VALUE_I > `TFF_BAND_MAX)
            TOO_BIG_O <= 1'b1;
          else
            band_reg <= CMD_VALUE_I[15:0];
        end
        if (CMD_I.filter_on)
          filt_cmd_reg <= 1'b1;
        else if (CMD_I.filter_off)
          filt_cmd_reg <= 1'b0;
        if (CMD_I.auto_send_on) begin
          auto_cmd_reg <= 1'b1;
          auto_dis_reg <= 1'b0;
        end else if (CMD_I.auto_send_off) begin
          auto_cmd_reg <= 1'b0;
          auto_dis_reg <= 1'b1;
        end
        if (CMD_I.arm_trigger)
          trig_mode_reg <= 1'b1;
        else if (CMD_I.continuous)
          trig_mode_reg <= 1'b0;
      end
    end
  end

  // continuous sample timer
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      tick_reg <= 32'h0000_0000;
    end else if (trig_mode_reg || tick_reg == 32'(SAMPLE_CYC - 1)) begin
      tick_reg <= 32'h0000_0000;
    end else begin
      tick_reg <= tick_reg + 32'h0000_0001;
    end
  end

  // sequencer: capture, compute, then wait out the ready time if triggered
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_reg     <= TFF_IDLE;
      from_trig_reg <= 1'b0;
      since_reg     <= 32'h0000_0000;
      SAMPLE_REQ_O  <= 1'b0;
      raw_reg       <= '0;
      div_start_reg <= 1'b0;
    end else begin
      SAMPLE_REQ_O  <= 1'b0;
      div_start_reg <= 1'b0;
      if (state_reg != TFF_IDLE)
        since_reg <= since_reg + 32'h0000_0001;
      case (state_reg)
        TFF_IDLE: begin
          since_reg <= 32'h0000_0000;
          if (trig_accept) begin
            // one measurement per accepted trigger
            state_reg     <= TFF_CAPTURE;
            from_trig_reg <= 1'b1;
            SAMPLE_REQ_O  <= 1'b1;
          end else if (!trig_mode_reg &&
                       tick_reg == 32'(SAMPLE_CYC - 1)) begin
            state_reg     <= TFF_CAPTURE;
            from_trig_reg <= 1'b0;
            SAMPLE_REQ_O  <= 1'b1;
          end
        end
        TFF_CAPTURE: begin
          // raw reading arrives from the converter; give up at the limit
          if (SAMPLE_VALID_I) begin
            raw_reg       <= SAMPLE_DATA_I;
            state_reg     <= TFF_COMPUTE;
            div_start_reg <= 1'b1;
          end else if (since_reg >= 32'(CAPTURE_CYC - 1)) begin
            state_reg <= TFF_IDLE;
          end
        end
        TFF_COMPUTE: begin
          // continuous results return straight to idle
          if (div_done)
            state_reg <= from_trig_reg ? TFF_WAIT_READY : TFF_IDLE;
        end
        TFF_WAIT_READY: begin
          // busy holds until the ready limit so late triggers are ignored
          if (since_reg >= 32'(READY_CYC - 1))
            state_reg <= TFF_IDLE;
        end
        default: state_reg <= TFF_IDLE;
      endcase
    end
  end

  // divider computes difference over factor
  tff_divider #(
    .W (DW)
  ) u_div (
    .clk_i      (CLK_I),
    .nrst_i     (NRST_I),
    .start_i    (div_start_reg),
    .dividend_i (diff),
    .divisor_i  (divisor_reg),
    .done_o     (div_done),
    .quotient_o (div_q)
  );

  // displayed value update at end of compute
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      disp_reg <= '0;
    end else if (div_done && state_reg == TFF_COMPUTE) begin
      if (!filter_on || !in_band)
        disp_reg <= raw_reg;
      else
        disp_reg <= RAW_W'(tff_ext(disp_reg) + div_q);
    end
  end

  // result pending, auto-send and read reply
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pending_reg    <= 1'b0;
      RESULT_READY_O <= 1'b0;
      SEND_O         <= 1'b0;
      READ_REPLY_O   <= 1'b0;
    end else begin
      SEND_O       <= 1'b0;
      READ_REPLY_O <= 1'b0;
      // read first, so a result landing in the same cycle stays pending
      if (CMD_I.field_read && UNIT_SELECTED_I) begin
        READ_REPLY_O <= 1'b1;
        pending_reg  <= 1'b0;
      end
      if (div_done && state_reg == TFF_COMPUTE && from_trig_reg) begin
        // triggered result is ready well before the limit
        RESULT_READY_O <= 1'b1;
        pending_reg    <= ~auto_send;
        SEND_O         <= auto_send;
      end else if (trig_accept) begin
        RESULT_READY_O <= 1'b0;
      end
    end
  end

  // zero offset from last measurement, used by later processing
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ZERO_OFFSET_O <= '0;
      ZERO_STORED_O <= 1'b0;
    end else begin
      ZERO_STORED_O <= 1'b0;
      // reload wipes the stored offset
      if (reload) begin
        ZERO_OFFSET_O <= '0;
      end else if (CMD_I.zero) begin
        ZERO_OFFSET_O <= disp_reg;
        ZERO_STORED_O <= 1'b1;
      end
    end
  end

  // status outputs
  assign FILTERED_O         = disp_reg;
  assign TRIG_MODE_O        = trig_mode_reg;
  assign FILTER_ON_O        = filter_on;
  assign BUSY_O             = (state_reg != TFF_IDLE);
  assign DIVISOR_O          = divisor_reg;
  assign BAND_O             = band_reg;
  // mode letters: D/A then C/V
  assign MODE_LETTER_AC_O   = AC_MODE_I ? 8'h41 : 8'h44;
  assign MODE_LETTER_TRIG_O = trig_mode_reg ? 8'h56 : 8'h43;

endmodule

`default_nettype wire

// File: testbench/tff_core_sva.sv
/*
  concurrent checks for the triggered field filter core.
  assumes a bind onto tff_core; sees only the ports of that module.
*/
`timescale 1ns/1ps
`default_nettype none
module tff_core_sva
  import tff_pkg::*;
#(
  parameter int READY_CYC = 200
) (
  // clock and reset
  input wire logic        CLK_I,
  input wire logic        NRST_I,
  // host side
  input wire tff_cmd_t    CMD_I,
  input wire logic [16:0] CMD_VALUE_I,
  input wire logic        UNIT_SELECTED_I,
  // watched outputs
  input wire logic        SAMPLE_REQ_O,
  input wire logic        RESULT_READY_O,
  input wire logic        SEND_O,
  input wire logic        READ_REPLY_O,
  input wire logic        ZERO_STORED_O,
  input wire logic        TRIG_MODE_O,
  input wire logic        BUSY_O,
  input wire logic        TOO_BIG_O,
  input wire logic [15:0] DIVISOR_O,
  input wire logic [15:0] BAND_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  // trigger taken by an armed, idle unit
  logic acc;
  assign acc = CMD_I.trigger && TRIG_MODE_O && !BUSY_O;
  property p_req; acc |=> SAMPLE_REQ_O; endproperty
  a_req: assert property (p_req) else $error("no capture request");
  property p_busy; acc |=> BUSY_O [*8]; endproperty
  a_busy: assert property (p_busy) else $error("busy dropped early");
  property p_ready;
    acc |=> !RESULT_READY_O ##[1:READY_CYC] RESULT_READY_O;
  endproperty
  a_ready: assert property (p_ready) else $error("result late");
  property p_unarmed; CMD_I.trigger && !TRIG_MODE_O |=> !$rose(BUSY_O);
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("unarmed trigger");
  property p_send; SEND_O |=> !SEND_O [*8]; endproperty
  a_send: assert property (p_send) else $error("repeated send");
  property p_read; CMD_I.field_read && UNIT_SELECTED_I |=> READ_REPLY_O;
  endproperty
  a_read: assert property (p_read) else $error("no read reply");
  property p_big;
    CMD_I.band_set && !CMD_I.reload && CMD_VALUE_I > 17'h0_FFFE
      |=> TOO_BIG_O && $stable(BAND_O);
  endproperty
  a_big: assert property (p_big) else $error("band too big taken");
  property p_div;
    CMD_I.divisor_set && !CMD_I.reload && CMD_VALUE_I != 17'h0_0000
      && !CMD_VALUE_I[16] |=> {1'b0, DIVISOR_O} == $past(CMD_VALUE_I);
  endproperty
  a_div: assert property (p_div) else $error("factor not set");
  property p_rld;
    CMD_I.reload |=> DIVISOR_O == 16'h0029 && BAND_O == 16'h0001;
  endproperty
  a_rld: assert property (p_rld) else $error("defaults not reloaded");
  property p_arm;
    CMD_I.arm_trigger && !CMD_I.continuous && !CMD_I.reload |=> TRIG_MODE_O;
  endproperty
  a_arm: assert property (p_arm) else $error("arm not taken");
  property p_zero; CMD_I.zero && TRIG_MODE_O |-> ##[1:4] ZERO_STORED_O;
  endproperty
  a_zero: assert property (p_zero) else $error("zero not stored");
endmodule
`default_nettype wire

// File: testbench/tff_conv_model.sv
/*
  behavioural raw converter that answers capture requests.
  assumes delay_i stays below the capture window of the core.
*/
`timescale 1ns/1ps
`default_nettype none
module tff_conv_model #(
  parameter int RAW_W = 24
) (
  input  wire logic                    clk_i,
  input  wire logic                    nrst_i,
  input  wire logic                    req_i,
  input  wire logic [7:0]              delay_i,
  input  wire logic signed [RAW_W-1:0] raw_i,
  output logic                         valid_o,
  output logic signed [RAW_W-1:0]      data_o
);
  logic [7:0] cnt;   // cycles left before the answer
  logic       pend;  // a request is outstanding
  // answer each request once; data is garbage outside the valid pulse
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt     <= 8'h00;
      pend    <= 1'b0;
      valid_o <= 1'b0;
      data_o  <= '0;
    end else begin
      valid_o <= 1'b0;
      data_o  <= ~data_o;
      if (req_i) begin
        pend <= 1'b1;
        cnt  <= delay_i;
      end else if (pend && cnt == 8'h00) begin
        pend    <= 1'b0;
        valid_o <= 1'b1;
        data_o  <= raw_i;
      end else if (pend) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/tb.sv
/*
  self-checking bench for the triggered field filter core.
  assumes short sample, capture and ready counts set below.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tff_pkg::*;
  localparam int SCYC = 200;
  localparam int RCYC = 200;
  logic clk, nrst, sel, rld_sw, s_valid, filt_sw, a_sw, ac, ex_snd;
  tff_cmd_t cmd_r;
  logic [16:0] val_r;
  logic [7:0] dly;
  logic signed [23:0] raw, s_data, filt, zoff, ex;
  logic [15:0] div_o, band_o;
  logic [7:0] l_ac, l_tr, u_adr;
  logic s_req, rdy, send, rep, zst, trm, fon, busy, big, rdn;
  int mismatches, checks_done, cyc, nreq, nsend, k, d;
  logic [31:0] s;
  tff_core #(.SAMPLE_CYC(SCYC), .CAPTURE_CYC(50), .READY_CYC(RCYC))
  tff_core_inst (.CLK_I(clk), .NRST_I(nrst), .CMD_I(cmd_r),
    .CMD_VALUE_I(val_r), .UNIT_SELECTED_I(sel), .FILTER_SWITCH_I(filt_sw),
    .AUTO_SEND_SWITCH_I(a_sw), .DEFAULTS_RELOAD_SWITCH_I(rld_sw),
    .AC_MODE_I(ac), .UNIT_ADDRESS_I(u_adr), .SAMPLE_REQ_O(s_req),
    .SAMPLE_VALID_I(s_valid), .SAMPLE_DATA_I(s_data), .FILTERED_O(filt),
    .RESULT_READY_O(rdy), .SEND_O(send), .READ_REPLY_O(rep),
    .ZERO_OFFSET_O(zoff), .ZERO_STORED_O(zst), .TRIG_MODE_O(trm),
    .FILTER_ON_O(fon), .BUSY_O(busy), .TOO_BIG_O(big),
    .RELOAD_DONE_O(rdn), .DIVISOR_O(div_o), .BAND_O(band_o),
    .MODE_LETTER_AC_O(l_ac), .MODE_LETTER_TRIG_O(l_tr));
  tff_conv_model #(.RAW_W(24)) tff_conv_model_inst (.clk_i(clk),
    .nrst_i(nrst), .req_i(s_req), .delay_i(dly), .raw_i(raw),
    .valid_o(s_valid), .data_o(s_data));
  // clock, event counters and hang guard
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (s_req === 1'b1) nreq++;
    if (send === 1'b1) nsend++;
    if (cyc == 20000) begin
      mismatches++;
      summarize();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // expected display after one in-band smoothing update
  function automatic logic signed [23:0] smooth(input logic signed [23:0] o,
                                                input logic signed [23:0] r,
                                                input int j);
    return o + (r - o) / j;
  endfunction
  // one-cycle command strobe by bit index, reload is bit 0
  task automatic go(input int n, input logic [16:0] v);
    @(posedge clk);
    cmd_r <= tff_cmd_t'(12'h001 << n);
    val_r <= v;
    @(posedge clk);
    cmd_r <= '0;
    #1;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp,
                     input string m);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    nrst = 1'b0; sel = 1'b0; rld_sw = 1'b0; filt_sw = 1'b0;
    a_sw = 1'b0;
    ac = 1'b0;
    u_adr = 8'h00;
    cmd_r = '0; val_r = '0; dly = 8'h00; raw = 24'sd500;
    s = 32'h0000_0764;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    chk(div_o, 24'h00_0029, "factor default");
    chk(band_o, 24'h00_0001, "band default");
    chk(l_tr, 24'h00_0043, "letter C");
    chk(l_ac, 24'h00_0044, "letter D");
    // continuous sampling period and unfiltered display
    @(posedge clk iff s_req === 1'b1);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (s_req !== 1'b1);
    chk(k, SCYC, "sample period");
    repeat (60) @(posedge clk);
    #1;
    chk(filt, 24'sd500, "raw shown when off");
    go(9, 17'h0_0007);
    chk(div_o, 24'h00_0007, "factor set");
    @(posedge clk);
    rld_sw <= 1'b1;
    @(posedge clk);
    #1;
    chk(rdn, 1'b1, "reload pulse");
    repeat (3) @(posedge clk);
    #1;
    chk(div_o, 24'h00_0029, "switch reload");
    go(8, 17'h0_FFFF);
    chk(big, 1'b1, "too big flagged");
    chk(band_o, 24'h00_0001, "band kept");
    go(8, 17'h0_FFFE);
    chk(band_o, 24'h00_FFFE, "band max");
    go(9, 17'h0_0004);
    go(7, 17'h0_0000);
    chk(trm, 1'b1, "armed");
    chk(l_tr, 24'h00_0056, "letter V");
    go(11, 17'h0_0000);
    chk(fon, 1'b1, "filter on");
    ex = 24'sd500;
    for (int i = 0; i < 8; i++) begin
      s = lfsr(s);
      if (i == 5) go(8, 17'h0_0010);
      d = (i == 5) ? 1000 : (i > 5) ? int'(s[3:0]) - 8 : int'(s[9:0]) - 512;
      @(posedge clk);
      raw <= ex + 24'(d);
      dly <= {3'b000, s[15:11]};
      sel <= s[0];
      // first two rounds: switch decides, unit 3 then unit 0
      a_sw <= 1'b1;
      u_adr <= (i == 0) ? 8'h03 : 8'h00;
      ex_snd = (i > 1) ? s[10] : (i == 1);
      if (i > 1) go(s[10] ? 4 : 3, 17'h0_0000);
      nreq = 0;
      nsend = 0;
      go(5, 17'h0_0000);
      go(5, 17'h0_0000);
      for (k = 0; k < 300 && rdy !== 1'b1; k++) @(posedge clk);
      for (k = 0; k < 300 && busy !== 1'b0; k++) @(posedge clk);
      #1;
      ex = (i == 5) ? ex + 24'(d) : smooth(ex, ex + 24'(d), 4);
      chk(nreq, 1, "one capture per trigger");
      chk(nsend, {23'h0, ex_snd}, "auto send count");
      chk(filt, ex, "display value");
      go(2, 17'h0_0000);
      chk(rep, sel, "read reply");
    end
    go(1, 17'h0_0000);
    chk(zst, 1'b1, "zero stored");
    repeat (4) @(posedge clk);
    #1;
    chk(zoff, ex, "zero offset");
    go(6, 17'h0_0000);
    go(5, 17'h0_0000);
    repeat (3) @(posedge clk);
    #1;
    chk(busy, 1'b0, "unarmed trigger");
    go(10, 17'h0_0000);
    chk(fon, 1'b0, "filter off");
    @(posedge clk);
    ac <= 1'b1;
    filt_sw <= 1'b1;
    @(posedge clk);
    #1;
    chk(l_ac, 24'h00_0041, "letter A");
    chk(fon, 1'b1, "filter by switch");
    summarize();
  end
endmodule
bind tff_core tff_core_sva #(.READY_CYC(READY_CYC)) tff_core_sva_inst (
  .CLK_I, .NRST_I, .CMD_I, .CMD_VALUE_I, .UNIT_SELECTED_I, .SAMPLE_REQ_O,
  .RESULT_READY_O, .SEND_O, .READ_REPLY_O, .ZERO_STORED_O, .TRIG_MODE_O,
  .BUSY_O, .TOO_BIG_O, .DIVISOR_O, .BAND_O);
`default_nettype wire
